// ---- hw/trg_pkg.sv ----
// shared constants for the trigger setup command handler
package trg_pkg;

    // register byte offsets on the bus
    localparam int unsigned ADDR_W    = 5;
    localparam logic [4:0]  OFF_CTRL  = 5'h00;
    localparam logic [4:0]  OFF_COUNT = 5'h04;
    localparam logic [4:0]  OFF_HOLD  = 5'h08;
    localparam logic [4:0]  OFF_HYST  = 5'h0C;
    localparam logic [4:0]  OFF_STAT  = 5'h10;
    localparam logic [4:0]  OFF_MASK  = 5'h14;
    localparam logic [4:0]  OFF_ERR   = 5'h18;

    // control word layout
    localparam int unsigned BIT_SLOPE = 0;
    localparam int unsigned BIT_FAST  = 1;
    localparam int unsigned BIT_ACAL  = 2;
    localparam int unsigned SRC_LSB   = 4;
    localparam int unsigned SRC_W     = 3;

    // trigger source codes, channels one to four first
    localparam logic [2:0] SOURCE_CHANNEL_ONE   = 3'h0;
    localparam logic [2:0] SOURCE_CHANNEL_TWO   = 3'h1;
    localparam logic [2:0] SOURCE_CHANNEL_THREE = 3'h2;
    localparam logic [2:0] SOURCE_CHANNEL_FOUR  = 3'h3;

    typedef enum logic {
        TRG_SLOPE_RISING  = 1'b0,
        TRG_SLOPE_FALLING = 1'b1
    } trg_slope_e;

    // limits: count plain, holdoff in ns, hysteresis in milli-dBm
    localparam logic signed [31:0] COUNT_MIN = 32'sh0000_0000;
    localparam logic signed [31:0] COUNT_MAX = 32'sh00F4_2400;
    localparam logic signed [31:0] HOLD_MIN  = 32'sh0000_03E8;
    localparam logic signed [31:0] HOLD_MAX  = 32'sh3B9A_CA00;
    localparam logic signed [31:0] HYST_MIN  = 32'sh0000_0000;
    localparam logic signed [31:0] HYST_MAX  = 32'sh0000_0BB8;

    // reset values
    localparam logic        RST_SLOPE = 1'b0;
    localparam logic        RST_FAST  = 1'b0;
    localparam logic        RST_ACAL  = 1'b1;
    localparam logic [2:0]  RST_SRC   = 3'h0;

    // sticky status bits
    localparam int unsigned ST_W        = 4;
    localparam int unsigned ST_CLIP_MIN = 0;
    localparam int unsigned ST_CLIP_MAX = 1;
    localparam int unsigned ST_CONFLICT = 2;
    localparam int unsigned ST_APPLIC   = 3;

    // error codes as signed words
    localparam logic [31:0] ERR_NONE     = 32'h0000_0000;
    localparam logic [31:0] ERR_RANGE    = 32'hFFFF_FF22;
    localparam logic [31:0] ERR_CONFLICT = 32'hFFFF_FF23;
    localparam logic [31:0] ERR_APPLIC   = 32'h0000_02C1;

    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // channels one and four carry the power sensors
    function automatic logic is_ch14(input logic [2:0] src);
        return (src == SOURCE_CHANNEL_ONE) || (src == SOURCE_CHANNEL_FOUR);
    endfunction

endpackage

// ---- hw/trg_clip.sv ----
// clamps a signed word into a closed range and flags the side clipped
`timescale 1ns/1ns
module trg_clip
    import trg_pkg::*;
#(
    parameter logic signed [31:0] LO = 32'sh0000_0000,
    parameter logic signed [31:0] HI = 32'sh0000_0001
)
(
    // value in
    input  wire logic signed [31:0] value,
    // clamped value and flags
    output logic signed [31:0]      clipped,
    output logic                    below,
    output logic                    above
);

    // pure compare, no state
    always_comb
    begin
        below   = value < LO;
        above   = value > HI;
        clipped = below ? LO : (above ? HI : value);
    end

endmodule // trg_clip

// ---- hw/trg_axil.sv ----
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/1ns
module trg_axil
    import trg_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address and data
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // register side
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_err
);

    logic              aw_full;
    logic              w_full;
    logic              next_aw_full;
    logic              next_w_full;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [31:0]       next_wr_data;
    logic [3:0]        next_wr_strb;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;

    // no new beat accepted until the pending response is gone
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_stb        = aw_full && w_full && !s_axi_bvalid;
    assign rd_addr       = s_axi_araddr;

    // next state of both channels
    always_comb
    begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_full = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_full  = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        if (wr_stb)
        begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata  = rd_data;
            next_rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    // registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            wr_addr      <= '0;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else
        begin
            aw_full      <= next_aw_full;
            w_full       <= next_w_full;
            wr_addr      <= next_wr_addr;
            wr_data      <= next_wr_data;
            wr_strb      <= next_wr_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

endmodule // trg_axil

// ---- hw/trg_cmd.sv ----
// trigger setup command handler: settings, checks, errors, interrupt
`timescale 1ns/1ns
module trg_cmd
    import trg_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // settings to the trigger unit
    output trg_slope_e             slope,
    output logic                   fast_en,
    output logic                   autocal_en,
    output logic [SRC_W-1:0]       trig_source,
    output logic [31:0]            ev_count,
    output logic [31:0]            holdoff_ns,
    output logic [31:0]            hyst_mdbm,
    // interrupt
    output logic                   irq
);

    logic              wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_err;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_err;
    logic [31:0]       wr_val;
    logic [31:0]       wr_cur;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic [31:0]       last_err;
    logic signed [31:0] cnt_clip;
    logic signed [31:0] hold_clip;
    logic signed [31:0] hyst_clip;
    logic              cnt_lo, cnt_hi, hold_lo, hold_hi, hyst_lo, hyst_hi;
    trg_slope_e        next_slope;
    logic              next_fast;
    logic              next_acal;
    logic [SRC_W-1:0]  next_src;
    logic [31:0]       next_count;
    logic [31:0]       next_hold;
    logic [31:0]       next_hyst;
    logic [ST_W-1:0]   next_status;
    logic [ST_W-1:0]   next_mask;
    logic [31:0]       next_err;
    logic [ST_W-1:0]   set_vec;
    logic [ST_W-1:0]   clr_vec;

    // bus front end
    trg_axil u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_stb        (wr_stb),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // one clamp per ranged setting
    trg_clip #(.LO(COUNT_MIN), .HI(COUNT_MAX)) u_clip_cnt (
        .value (wr_val), .clipped (cnt_clip),
        .below (cnt_lo), .above (cnt_hi)
    );
    trg_clip #(.LO(HOLD_MIN), .HI(HOLD_MAX)) u_clip_hold (
        .value (wr_val), .clipped (hold_clip),
        .below (hold_lo), .above (hold_hi)
    );
    trg_clip #(.LO(HYST_MIN), .HI(HYST_MAX)) u_clip_hyst (
        .value (wr_val), .clipped (hyst_clip),
        .below (hyst_lo), .above (hyst_hi)
    );

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_COUNT) || (a == OFF_HOLD) ||
               (a == OFF_HYST) || (a == OFF_STAT) || (a == OFF_MASK) ||
               (a == OFF_ERR);
    endfunction

    // query answers: stored values, unmapped reads as zero
    function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == OFF_CTRL)
        begin
            d[BIT_SLOPE]            = slope;
            d[BIT_FAST]             = fast_en;
            d[BIT_ACAL]             = autocal_en;
            d[SRC_LSB +: SRC_W]     = trig_source;
        end
        else if (a == OFF_COUNT)
            d = ev_count;
        else if (a == OFF_HOLD)
            d = holdoff_ns;
        else if (a == OFF_HYST)
            d = hyst_mdbm;
        else if (a == OFF_STAT)
            d[ST_W-1:0] = status;
        else if (a == OFF_MASK)
            d[ST_W-1:0] = mask;
        else if (a == OFF_ERR)
            d = last_err;
        return d;
    endfunction

    // status bits for a clamp result
    function automatic logic [ST_W-1:0] range_flags(input logic lo,
                                                    input logic hi);
        logic [ST_W-1:0] f;
        f = '0;
        f[ST_CLIP_MIN] = lo;
        f[ST_CLIP_MAX] = hi;
        return f;
    endfunction

    // byte strobes merge into the current word, so partial writes work
    always_comb
    begin
        // current word held apart, a call result cannot be sliced
        wr_cur = rd_mux(wr_addr);
        for (int i = 0; i < 4; i++)
            wr_val[i*8 +: 8] = wr_strb[i] ? wr_data[i*8 +: 8]
                                          : wr_cur[i*8 +: 8];
        rd_data = rd_mux(rd_addr);
        rd_err  = !mapped(rd_addr);
        wr_err  = !mapped(wr_addr);
        irq     = |(status & mask);
    end

    // command decode and checks
    always_comb
    begin
        next_slope  = slope;
        next_fast   = fast_en;
        next_acal   = autocal_en;
        next_src    = trig_source;
        next_count  = ev_count;
        next_hold   = holdoff_ns;
        next_hyst   = hyst_mdbm;
        next_mask   = mask;
        next_err    = last_err;
        set_vec     = '0;
        clr_vec     = '0;
        if (wr_stb)
        begin
            if (wr_addr == OFF_CTRL)
            begin
                next_slope = trg_slope_e'(wr_val[BIT_SLOPE]);
                next_src   = wr_val[SRC_LSB +: SRC_W];
                next_acal  = wr_val[BIT_ACAL];
                // a source change off ch1/ch4 also drops the fast path
                next_fast  = wr_val[BIT_FAST] && is_ch14(next_src);
                if (wr_val[BIT_FAST] && !is_ch14(next_src))
                begin
                    set_vec[ST_CONFLICT] = 1'b1;
                    next_err             = ERR_CONFLICT;
                end
                if (next_fast && !fast_en)
                    next_acal = 1'b0;
            end
            else if (wr_addr == OFF_COUNT)
            begin
                next_count = cnt_clip;
                set_vec    = range_flags(cnt_lo, cnt_hi);
                if (cnt_lo || cnt_hi)
                    next_err = ERR_RANGE;
            end
            else if (wr_addr == OFF_HOLD)
            begin
                next_hold = hold_clip;
                set_vec   = range_flags(hold_lo, hold_hi);
                if (hold_lo || hold_hi)
                    next_err = ERR_RANGE;
            end
            else if (wr_addr == OFF_HYST)
            begin
                if (!is_ch14(trig_source))
                begin
                    set_vec[ST_APPLIC] = 1'b1;
                    next_err           = ERR_APPLIC;
                end
                else
                begin
                    next_hyst = hyst_clip;
                    set_vec   = range_flags(hyst_lo, hyst_hi);
                    if (hyst_lo || hyst_hi)
                        next_err = ERR_RANGE;
                end
            end
            else if (wr_addr == OFF_STAT)
                clr_vec = wr_val[ST_W-1:0];
            else if (wr_addr == OFF_MASK)
                next_mask = wr_val[ST_W-1:0];
        end
        // a new event beats a clear in the same cycle
        next_status = (status & ~clr_vec) | set_vec;
    end

    // settings and status registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slope       <= trg_slope_e'(RST_SLOPE);
            fast_en     <= RST_FAST;
            autocal_en  <= RST_ACAL;
            trig_source <= RST_SRC;
            ev_count    <= COUNT_MIN;
            holdoff_ns  <= HOLD_MIN;
            hyst_mdbm   <= HYST_MIN;
            status      <= '0;
            mask        <= '0;
            last_err    <= ERR_NONE;
        end
        else
        begin
            slope       <= next_slope;
            fast_en     <= next_fast;
            autocal_en  <= next_acal;
            trig_source <= next_src;
            ev_count    <= next_count;
            holdoff_ns  <= next_hold;
            hyst_mdbm   <= next_hyst;
            status      <= next_status;
            mask        <= next_mask;
            last_err    <= next_err;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // checks on the stored settings
    a_reset_defaults: assert property
        ($rose(aresetn) |-> slope == TRG_SLOPE_RISING && !fast_en &&
         ev_count == COUNT_MIN)
        else $error("settings not at defaults after reset");
    a_count_clip_max: assert property
        (wr_stb && wr_addr == OFF_COUNT && $signed(wr_val) > COUNT_MAX |=>
         ev_count == COUNT_MAX && status[ST_CLIP_MAX] &&
         last_err == ERR_RANGE)
        else $error("count above range not clipped to maximum");
    a_count_in_range: assert property
        ($signed(ev_count) >= COUNT_MIN && $signed(ev_count) <= COUNT_MAX)
        else $error("event count outside its range");
    a_hold_in_range: assert property
        ($signed(holdoff_ns) >= HOLD_MIN && $signed(holdoff_ns) <= HOLD_MAX)
        else $error("holdoff outside its range");
    a_hyst_in_range: assert property
        ($signed(hyst_mdbm) >= HYST_MIN && $signed(hyst_mdbm) <= HYST_MAX)
        else $error("hysteresis outside its range");
    a_fast_conflict: assert property
        (wr_stb && wr_addr == OFF_CTRL && wr_val[BIT_FAST] &&
         !is_ch14(wr_val[SRC_LSB +: SRC_W]) |=> !fast_en &&
         status[ST_CONFLICT] && last_err == ERR_CONFLICT)
        else $error("fast trigger kept on a wrong source");
    a_fast_source: assert property
        (fast_en |-> is_ch14(trig_source))
        else $error("fast trigger on with a wrong source");
    a_autocal_clear: assert property
        ($rose(fast_en) |-> !autocal_en)
        else $error("autocal still on after fast trigger enable");
    a_hyst_reject: assert property
        (wr_stb && wr_addr == OFF_HYST && !is_ch14(trig_source) |=>
         $stable(hyst_mdbm) && status[ST_APPLIC] && last_err == ERR_APPLIC)
        else $error("hysteresis write not rejected");
    a_query_count: assert property
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_COUNT |=>
         s_axi_rvalid && s_axi_rdata == $past(ev_count))
        else $error("count query does not return stored value");

    // main scenarios
    c_fast_on:   cover property ($rose(fast_en));
    c_hyst_clip: cover property (wr_stb && wr_addr == OFF_HYST && hyst_hi);
    c_hold_clip: cover property (wr_stb && wr_addr == OFF_HOLD && hold_lo);
    c_irq:       cover property ($rose(irq));

endmodule // trg_cmd

// ---- bench/trg_host.sv ----
// host model issuing register commands over axi4-lite
`timescale 1ns/1ns
module trg_host
(
    // clock
    input  wire logic        aclk,
    // write side
    output logic [4:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read side
    output logic [4:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // response code of the last write, for the bench to check
    logic [1:0] last_b;
    // idle bus at time zero
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // one write; released address and data show their inverse
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid  <= wvalid && !wready;
            if (awvalid && awready)
                awaddr <= ~a;
            if (wvalid && wready)
                wdata <= ~d;
        end
        while (!bvalid);
        last_b = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    // one read; trailing edge keeps two calls from sharing a step
    task automatic rd(input logic [4:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            arvalid <= arvalid && !arready;
            if (arvalid && arready)
                araddr <= ~a;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule // trg_host

// ---- bench/trigger_setup_command_handler_tb.sv ----
// self-checking bench for the trigger setup command handler
`timescale 1ns/1ns
module trigger_setup_command_handler_tb
    import trg_pkg::*;
;
    typedef struct packed {
        logic [4:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic [31:0] e;
        logic [3:0]  s;
    } trg_row_s;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, fast_en, irq;
    logic        autocal_en;
    trg_slope_e  slope;
    logic [2:0]  trig_source;
    logic [31:0] ev_count, holdoff_ns, hyst_mdbm;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          num_errors, checks;
    trg_row_s    rows [12];

    trg_cmd trg_cmd_i (.aclk, .aresetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .slope, .fast_en, .autocal_en,
        .trig_source, .ev_count, .holdoff_ns, .hyst_mdbm, .irq);
    trg_host trg_host_i (.aclk, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    // 100 ns clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // settings pins packed like the register at that address
    function automatic logic [31:0] pins(input logic [4:0] a);
        if (a == OFF_CTRL)
            return {25'h0, trig_source, 1'b0, autocal_en, fast_en, slope};
        else if (a == OFF_COUNT)
            return ev_count;
        else if (a == OFF_HOLD)
            return holdoff_ns;
        return hyst_mdbm;
    endfunction
    task automatic conclude();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reset for two edges, then every setting back at its default
    task automatic rst_and_chk();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        trg_host_i.rd(OFF_CTRL, v, r);
        chk("ctrl", v, 32'h0000_0004);
        chk("fast_en", {31'h0, fast_en}, 32'h0);
        chk("ctrl pins", pins(OFF_CTRL), 32'h0000_0004);
        trg_host_i.rd(OFF_COUNT, v, r);
        chk("count", v, 32'h0);
        trg_host_i.rd(OFF_HOLD, v, r);
        chk("holdoff", v, 32'h0000_03E8);
        trg_host_i.rd(OFF_HYST, v, r);
        chk("hyst", v, 32'h0);
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #1000000;
        num_errors++;
        conclude();
    end
    initial
    begin
        aresetn = 1'b0;
        // address, data, readback, last error, status; source left at reset for the first rows
        rows = '{'{OFF_COUNT, 32'hA, 32'hA, 32'h0, 4'h0},
            '{OFF_COUNT, 32'hF42401, 32'hF42400, 32'hFFFFFF22, 4'h2},
            '{OFF_COUNT, 32'hFFFFFFFF, 32'h0, 32'hFFFFFF22, 4'h1},
            '{OFF_HOLD, 32'h1F4, 32'h3E8, 32'hFFFFFF22, 4'h1},
            '{OFF_HOLD, 32'h77359400, 32'h3B9ACA00, 32'hFFFFFF22, 4'h2},
            '{OFF_HYST, 32'h1388, 32'hBB8, 32'hFFFFFF22, 4'h2},
            '{OFF_HYST, 32'h3E8, 32'h3E8, 32'hFFFFFF22, 4'h0},
            '{OFF_CTRL, 32'h5, 32'h5, 32'hFFFFFF22, 4'h0},
            '{OFF_CTRL, 32'h36, 32'h32, 32'hFFFFFF22, 4'h0},
            '{OFF_CTRL, 32'h16, 32'h14, 32'hFFFFFF23, 4'h4},
            '{OFF_HYST, 32'h7D0, 32'h3E8, 32'h2C1, 4'h8},
            '{OFF_CTRL, 32'h22, 32'h20, 32'hFFFFFF23, 4'h4}};
        rst_and_chk();
        foreach (rows[i])
        begin
            trg_host_i.wr(OFF_STAT, 32'hF);
            trg_host_i.wr(rows[i].a, rows[i].d);
            chk("bresp", {30'h0, trg_host_i.last_b}, {30'h0, RESP_OKAY});
            trg_host_i.rd(rows[i].a, v, r);
            chk("value", v, rows[i].q);
            chk("pins", pins(rows[i].a), rows[i].q);
            trg_host_i.rd(OFF_ERR, v, r);
            chk("lasterr", v, rows[i].e);
            trg_host_i.rd(OFF_STAT, v, r);
            chk("status", v, {28'h0, rows[i].s});
        end
        // conflict still pending: masked, unmasked, then cleared
        chk("irq", {31'h0, irq}, 32'h0);
        trg_host_i.wr(OFF_MASK, 32'h4);
        chk("irq", {31'h0, irq}, 32'h1);
        trg_host_i.wr(OFF_STAT, 32'h4);
        chk("irq", {31'h0, irq}, 32'h0);
        trg_host_i.rd(5'h1C, v, r);
        chk("resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        chk("unmapped", v, 32'h0);
        trg_host_i.wr(5'h1C, 32'h1);
        chk("bresp", {30'h0, trg_host_i.last_b}, {30'h0, RESP_SLVERR});
        rst_and_chk();
        conclude();
    end
endmodule // trigger_setup_command_handler_tb
